// File: hw/pgc_top.sv
// PWM generator with control options, APB registers and interrupt
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pgc_top (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Master time bases, same clock domain
  input  wire logic        pri_tb_sync_in,
  input  wire logic        pri_tb_tick_in,
  input  wire logic        sec_tb_sync_in,
  input  wire logic        sec_tb_tick_in,
  // Pins from the board
  input  wire logic        current_limit_in,
  input  wire logic        dead_comp_input_in,
  // Power stage and interrupt
  output logic             high_side_output_out,
  output logic             low_side_output_out,
  output logic             irq_out
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] period;
    logic [15:0] duty_shadow;
    logic [15:0] duty_active;
    logic [15:0] phase;
    logic [11:0] dead;
    logic [1:0]  glb;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [15:0] cnt;
    logic        down;
    logic        pwm_ref;
    logic [2:0]  lim_sync;
    logic [1:0]  comp_sync;
    logic        irq;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } pgc_state_t;

  pgc_state_t cur_ff;
  pgc_state_t nxt_ff;

  logic        acc_now;
  logic        wr_now;
  logic        gen_en;
  logic        independent_timebase;
  logic        ca_mode;
  logic        tb_tick;
  logic        tb_sync;
  logic        limit_evt;
  logic        boundary;
  logic [15:0] duty_eff;
  logic [15:0] phase_eff;
  logic [15:0] period_eff;
  logic [11:0] dead_eff;
  logic [31:0] rd_mux;
  logic        addr_ok;

  // Decoded settings shared by the counter and the shaper
  always_comb begin
    gen_en  = cur_ff.glb[pgc_pkg::GLB_EN];
    independent_timebase     = cur_ff.ctrl[pgc_pkg::CTRL_ITB];
    // Alignment bit is ignored while the master time base is used
    ca_mode = independent_timebase & cur_ff.ctrl[pgc_pkg::CTRL_CAM];
    // Without a secondary base the select bit falls back to the primary
    if (cur_ff.ctrl[pgc_pkg::CTRL_TBS] && pgc_pkg::SEC_TB_PRESENT) begin
      tb_tick = sec_tb_tick_in;
      tb_sync = sec_tb_sync_in;
    end else begin
      tb_tick = pri_tb_tick_in;
      tb_sync = pri_tb_sync_in;
    end
    // Only the synced limit pin is edge detected, never the first stage
    limit_evt = cur_ff.lim_sync[1] & ~cur_ff.lim_sync[2];
  end

  // Center mode quantises timing values to eight-count steps
  always_comb begin
    if (ca_mode) begin
      duty_eff   = {cur_ff.duty_active[15:3], 3'h0};
      phase_eff  = {cur_ff.phase[15:3], 3'h0};
      dead_eff   = {cur_ff.dead[11:3], 3'h0};
      period_eff = {cur_ff.period[15:3], 3'h0};
    end else begin
      duty_eff   = cur_ff.duty_active;
      phase_eff  = cur_ff.phase;
      dead_eff   = cur_ff.dead;
      period_eff = cur_ff.period;
    end
  end

  // APB decode: one wait state so read data comes from a flop
  always_comb begin
    acc_now = psel & penable & cur_ff.ready;
    wr_now  = acc_now & pwrite;
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      pgc_pkg::OFF_CTRL: begin
        // Bit four is not stored and so reads zero
        rd_mux = {16'h0000, cur_ff.ctrl};
      end
      pgc_pkg::OFF_PERIOD: begin
        rd_mux = {16'h0000, cur_ff.period};
      end
      pgc_pkg::OFF_DUTY: begin
        rd_mux = {16'h0000, cur_ff.duty_shadow};
      end
      pgc_pkg::OFF_PHASE: begin
        rd_mux = {16'h0000, cur_ff.phase};
      end
      pgc_pkg::OFF_DEAD: begin
        rd_mux = {20'h00000, cur_ff.dead};
      end
      pgc_pkg::OFF_GLOBAL: begin
        rd_mux = {30'h0000_0000, cur_ff.glb};
      end
      pgc_pkg::OFF_STATUS: begin
        rd_mux = {30'h0000_0000, cur_ff.status};
      end
      pgc_pkg::OFF_MASK: begin
        rd_mux = {30'h0000_0000, cur_ff.mask};
      end
      pgc_pkg::OFF_COUNT: begin
        rd_mux = {15'h0000, cur_ff.down, cur_ff.cnt};
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Time base counter and next state of everything
  always_comb begin
    nxt_ff   = cur_ff;
    boundary = 1'b0;

    // Two-flop synchronisers for the board pins
    nxt_ff.lim_sync  = {cur_ff.lim_sync[1:0], current_limit_in};
    nxt_ff.comp_sync = {cur_ff.comp_sync[0], dead_comp_input_in};

    // Counter: phase is the restart value at every time-base reset
    if (!gen_en) begin
      nxt_ff.cnt  = phase_eff;
      nxt_ff.down = 1'b0;
    end else if (independent_timebase && cur_ff.ctrl[pgc_pkg::CTRL_XRES] && limit_evt) begin
      nxt_ff.cnt  = phase_eff;
      nxt_ff.down = 1'b0;
      boundary    = 1'b1;
    end else if (!independent_timebase && tb_sync) begin
      nxt_ff.cnt  = phase_eff;
      nxt_ff.down = 1'b0;
      boundary    = 1'b1;
    end else if (tb_tick) begin
      if (ca_mode) begin
        // Up to the period, then down to zero; zero is the boundary
        if (!cur_ff.down) begin
          if (cur_ff.cnt >= period_eff) begin
            nxt_ff.down = 1'b1;
            nxt_ff.cnt  = cur_ff.cnt - 16'h0001;
          end else begin
            nxt_ff.cnt = cur_ff.cnt + 16'h0001;
          end
        end else if (cur_ff.cnt == 16'h0000) begin
          nxt_ff.down = 1'b0;
          nxt_ff.cnt  = 16'h0001;
          boundary    = 1'b1;
        end else begin
          nxt_ff.cnt = cur_ff.cnt - 16'h0001;
        end
      end else if (cur_ff.cnt >= period_eff) begin
        nxt_ff.cnt  = 16'h0000;
        nxt_ff.down = 1'b0;
        boundary    = 1'b1;
      end else begin
        nxt_ff.cnt  = cur_ff.cnt + 16'h0001;
        nxt_ff.down = 1'b0;
      end
    end

    // Reference wave; in center mode it is symmetric about zero
    nxt_ff.pwm_ref = gen_en & (cur_ff.cnt < duty_eff);

    // Active duty follows the shadow at once or only at the boundary
    if (cur_ff.ctrl[pgc_pkg::CTRL_IUE] || boundary) begin
      nxt_ff.duty_active = cur_ff.duty_shadow;
    end

    // APB handshake: ready pulses in the second access cycle
    nxt_ff.ready  = psel & penable & ~cur_ff.ready;
    nxt_ff.slverr = psel & penable & ~cur_ff.ready & ~addr_ok;
    if (psel && penable && !cur_ff.ready) begin
      nxt_ff.rdata = pwrite ? 32'h0000_0000 : rd_mux;
    end

    // Register writes take effect on the completing edge only
    if (wr_now) begin
      case (paddr)
        pgc_pkg::OFF_CTRL: begin
          // Mode bits are not locked; software keeps them steady
          nxt_ff.ctrl = pwdata[15:0] & pgc_pkg::CTRL_WMASK;
        end
        pgc_pkg::OFF_PERIOD: begin
          nxt_ff.period = pwdata[15:0];
        end
        pgc_pkg::OFF_DUTY: begin
          nxt_ff.duty_shadow = pwdata[15:0];
        end
        pgc_pkg::OFF_PHASE: begin
          nxt_ff.phase = pwdata[15:0];
        end
        pgc_pkg::OFF_DEAD: begin
          nxt_ff.dead = pwdata[11:0];
        end
        pgc_pkg::OFF_GLOBAL: begin
          nxt_ff.glb = pwdata[1:0];
        end
        pgc_pkg::OFF_MASK: begin
          nxt_ff.mask = pwdata[1:0];
        end
        default: begin
          nxt_ff.mask = cur_ff.mask;
        end
      endcase
    end

    // Sticky status: write one clears, a new event in that cycle wins
    if (wr_now && paddr == pgc_pkg::OFF_STATUS) begin
      nxt_ff.status = cur_ff.status & ~pwdata[1:0];
    end
    if (boundary) begin
      nxt_ff.status[pgc_pkg::ST_BOUND] = 1'b1;
    end
    if (limit_evt && gen_en) begin
      nxt_ff.status[pgc_pkg::ST_LIMIT] = 1'b1;
    end
    nxt_ff.irq = |(nxt_ff.status & nxt_ff.mask);
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cur_ff             <= '0;
      cur_ff.ctrl        <= pgc_pkg::RST_CTRL;
      cur_ff.period      <= pgc_pkg::RST_PERIOD;
      cur_ff.duty_shadow <= pgc_pkg::RST_DUTY;
      cur_ff.duty_active <= pgc_pkg::RST_DUTY;
      cur_ff.phase       <= pgc_pkg::RST_PHASE;
      cur_ff.dead        <= pgc_pkg::RST_DEAD;
      cur_ff.glb         <= pgc_pkg::RST_GLOBAL;
      cur_ff.status      <= pgc_pkg::RST_IRQ;
      cur_ff.mask        <= pgc_pkg::RST_IRQ;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // Dead-time shaping toward the power stage
  pgc_deadtime u_deadtime (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .en_in      (gen_en),
    .ref_in     (cur_ff.pwm_ref),
    .mode_in    (cur_ff.ctrl[pgc_pkg::CTRL_DTM +: 2]),
    .pol_in     (cur_ff.ctrl[pgc_pkg::CTRL_POL]),
    .comp_in    (cur_ff.comp_sync[1]),
    .dt_in      (dead_eff),
    .high_out   (high_side_output_out),
    .low_out    (low_side_output_out)
  );

  assign prdata  = cur_ff.rdata;
  assign pready  = cur_ff.ready;
  assign pslverr = cur_ff.slverr;
  assign irq_out = cur_ff.irq;

endmodule : pgc_top
`default_nettype wire

// File: hw/pgc_pkg.sv
// Package: register map, field positions, reset values and modes
package pgc_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_DUTY   = 8'h08;
  localparam logic [7:0] OFF_PHASE  = 8'h0C;
  localparam logic [7:0] OFF_DEAD   = 8'h10;
  localparam logic [7:0] OFF_GLOBAL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK   = 8'h1C;
  localparam logic [7:0] OFF_COUNT  = 8'h20;

  // Control register field positions
  localparam int CTRL_IUE  = 0;
  localparam int CTRL_XRES = 1;
  localparam int CTRL_CAM  = 2;
  localparam int CTRL_TBS  = 3;
  localparam int CTRL_RSVD = 4;
  localparam int CTRL_POL  = 5;
  localparam int CTRL_DTM  = 6;
  localparam int CTRL_ITB  = 9;

  // Global register field positions
  localparam int GLB_EN    = 0;
  localparam int GLB_CURRENT_LIMIT_MODE = 1;

  // Status and mask bit positions
  localparam int ST_BOUND  = 0;
  localparam int ST_LIMIT  = 1;

  // Writable control bits; bit 4 is kept out of this mask
  localparam logic [15:0] CTRL_WMASK = 16'h02EF;

  // Values after reset
  localparam logic [15:0] RST_CTRL   = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'h00FF;
  localparam logic [15:0] RST_DUTY   = 16'h0000;
  localparam logic [15:0] RST_PHASE  = 16'h0000;
  localparam logic [11:0] RST_DEAD   = 12'h000;
  localparam logic [1:0]  RST_GLOBAL = 2'h0;
  localparam logic [1:0]  RST_IRQ    = 2'h0;

  // Center-aligned mode drops this many low bits of timing values
  localparam int CA_DROP_BITS = 3;
  // Finest center-aligned edge step at the fastest prescaler, in ps
  localparam int CA_RES_PS    = 8320;

  // Whether a secondary master time base exists in this build
  localparam logic SEC_TB_PRESENT = 1'b1;

  // Dead-time mode codes
  typedef enum logic [1:0] {
    DTM_POS  = 2'h0,
    DTM_NEG  = 2'h1,
    DTM_OFF  = 2'h2,
    DTM_COMP = 2'h3
  } pgc_dtm_t;

endpackage : pgc_pkg

// File: hw/pgc_deadtime.sv
// Dead-time shaper: turns a reference wave into high and low outputs
`timescale 1ns/1ns
`default_nettype none
module pgc_deadtime (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // Reference and settings
  input  wire logic        en_in,
  input  wire logic        ref_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic        pol_in,
  input  wire logic        comp_in,
  input  wire logic [11:0] dt_in,
  // Power stage drive
  output logic             high_out,
  output logic             low_out
);

  typedef struct packed {
    logic        prev;
    logic [13:0] elapsed;
    logic        high;
    logic        low;
  } pgc_dt_state_t;

  pgc_dt_state_t cur_ff;
  pgc_dt_state_t nxt_ff;

  logic [13:0] h_on;
  logic [13:0] l_on;
  logic [13:0] h_off;
  logic [13:0] l_off;
  logic        short_high;

  // Per-edge delays chosen by the dead-time mode
  always_comb begin
    h_on       = 14'h0000;
    l_on       = 14'h0000;
    h_off      = 14'h0000;
    l_off      = 14'h0000;
    short_high = 1'b0;
    case (pgc_pkg::pgc_dtm_t'(mode_in))
      pgc_pkg::DTM_POS: begin
        // Turn-on delayed on both sides: a gap, never overlap
        h_on = {2'b00, dt_in};
        l_on = {2'b00, dt_in};
      end
      pgc_pkg::DTM_NEG: begin
        // Turn-off delayed instead: outputs overlap by the dead time
        h_off = {2'b00, dt_in};
        l_off = {2'b00, dt_in};
      end
      pgc_pkg::DTM_OFF: begin
        h_on = 14'h0000;
      end
      pgc_pkg::DTM_COMP: begin
        // Polarity only looked at in this mode
        short_high = pol_in ? comp_in : ~comp_in;
        // Whole gap moved to one side, so total dead time is kept
        if (short_high) begin
          h_on = {1'b0, dt_in, 1'b0};
        end else begin
          l_on = {1'b0, dt_in, 1'b0};
        end
      end
      default: begin
        h_on = 14'h0000;
      end
    endcase
  end

  // Time since the last reference edge, saturating
  always_comb begin
    nxt_ff      = cur_ff;
    nxt_ff.prev = ref_in;
    if (ref_in != cur_ff.prev) begin
      nxt_ff.elapsed = 14'h0000;
    end else if (cur_ff.elapsed != 14'h3FFF) begin
      nxt_ff.elapsed = cur_ff.elapsed + 14'h0001;
    end
    if (!en_in) begin
      nxt_ff.high = 1'b0;
      nxt_ff.low  = 1'b0;
    end else if (ref_in) begin
      nxt_ff.high = (nxt_ff.elapsed >= h_on);
      nxt_ff.low  = (nxt_ff.elapsed < l_off);
    end else begin
      nxt_ff.high = (nxt_ff.elapsed < h_off);
      nxt_ff.low  = (nxt_ff.elapsed >= l_on);
    end
  end

  // State register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign high_out = cur_ff.high;
  assign low_out  = cur_ff.low;

endmodule : pgc_deadtime
`default_nettype wire

// File: sim/pgc_properties.sv
// Checker: bus handshake and drive properties of the PWM generator
`timescale 1ns/1ns
`default_nettype none
module pgc_properties (
  // Clock, reset and bus
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Drive and interrupt
  input wire logic        high_side_output_out,
  input wire logic        low_side_output_out,
  input wire logic        irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic       wr_ok;
  logic [1:0] mode_ff;
  logic       en_ff;
  logic [5:0] quiet_ff;
  // A write lands at the edge where pready is seen
  assign wr_ok = psel && penable && pready && pwrite;
  // Shadow mode and enable; quiet hides dead-time tails after a change
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mode_ff  <= 2'h0;
      en_ff    <= 1'b0;
      quiet_ff <= 6'h00;
    end else begin
      if (wr_ok && paddr == 8'h00) mode_ff <= pwdata[7:6];
      if (wr_ok && paddr == 8'h14) en_ff <= pwdata[0];
      if (wr_ok && (paddr == 8'h00 || paddr[7:3] == 5'h02)) quiet_ff <= 6'h00;
      else if (quiet_ff != 6'h3F) quiet_ff <= quiet_ff + 6'h01;
    end
  end
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held over one cycle");
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  ready_in_access_a: assert property
    (pready |-> psel && penable && $past(penable))
    else $error("pready outside an access phase");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (pready && paddr > 8'h20
    |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  mapped_ok_a: assert property
    (pready && paddr[1:0] == 2'h0 && paddr <= 8'h20 |-> !pslverr)
    else $error("mapped access refused");
  ctrl_bits_a: assert property
    (pready && !pwrite && paddr == 8'h00
    |-> (prdata & ~32'h0000_02EF) == 32'h0)
    else $error("control reads a bit that is not kept");
  reset_quiet_a: assert property ($past(sys_rst_in) |-> !irq_out
    && !high_side_output_out && !low_side_output_out)
    else $error("output active after reset");
  no_overlap_a: assert property
    (quiet_ff == 6'h3F && mode_ff != 2'h1
    |-> !(high_side_output_out && low_side_output_out))
    else $error("both switches on outside negative dead time");
  off_quiet_a: assert property (quiet_ff == 6'h3F && !en_ff
    |-> !high_side_output_out && !low_side_output_out)
    else $error("drive active while disabled");
endmodule : pgc_properties
bind pgc_top pgc_properties pgc_properties_inst (.clk_sys_in, .sys_rst_in,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .high_side_output_out, .low_side_output_out, .irq_out);
`default_nettype wire

// File: sim/pgc_stage.sv
// Power stage model: measures drive pulses and senses load direction
`timescale 1ns/1ns
`default_nettype none
module pgc_stage (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Drive and load state
  input  wire logic       high_in,
  input  wire logic       low_in,
  input  wire logic       load_dir_in,
  // Sensed direction and widths of the last period
  output logic            comp_sense_out,
  output logic [7:0]      hi_n_out,
  output logic [7:0]      lo_n_out,
  output logic [7:0]      per_n_out,
  output logic [7:0]      seen_out
);
  logic [7:0] hc, lc, pc;
  logic       hp;
  // Sense level follows the load current; it never floats
  assign comp_sense_out = load_dir_in;
  // A period runs from one rise of the high switch to the next
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      {hc, lc, pc, hp, seen_out} <= '0;
      {hi_n_out, lo_n_out, per_n_out} <= '0;
    end else begin
      hp <= high_in;
      if (high_in && !hp) begin
        {hi_n_out, lo_n_out, per_n_out} <= {hc, lc, pc};
        {hc, lc, pc} <= {8'h01, 7'h00, low_in, 8'h01};
        seen_out <= seen_out + 8'h01;
      end else begin
        {hc, lc, pc} <= {hc + 8'(high_in), lc + 8'(low_in), pc + 8'h01};
      end
    end
  end
endmodule : pgc_stage
`default_nettype wire

// File: sim/pgc_top_test.sv
// Testbench: registers, dead time, counting, limit reset and update
`timescale 1ns/1ns
`default_nettype none
module pgc_top_test;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pri_tick = 1'b1;
  logic        pri_sync = 1'b0;
  logic        limit_pin = 1'b0;
  logic        load_dir = 1'b0;
  logic [31:0] prdata, rq, q1;
  logic        pready, pslverr, re, hi, lo, irq, comp;
  logic [7:0]  hi_n, lo_n, per_n, seen, h1;
  int          n_mismatch = 0;
  int          tests_run = 0;
  // Mode, polarity, sense nibbles; expected high and low widths
  logic [31:0] tbl [7] = '{32'h0010_1C1C, 32'h0100_2424, 32'h0211_2020,
    32'h0310_2018, 32'h0311_1820, 32'h0300_1820, 32'h0301_2018};
  pgc_top pgc_top_inst (.clk_sys_in, .sys_rst_in, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pri_tb_sync_in(pri_sync), .pri_tb_tick_in(pri_tick),
    .sec_tb_sync_in(1'b0), .sec_tb_tick_in(1'b0),
    .current_limit_in(limit_pin), .dead_comp_input_in(comp),
    .high_side_output_out(hi), .low_side_output_out(lo), .irq_out(irq));
  pgc_stage pgc_stage_inst (.clk_in(clk_sys_in), .rst_in(sys_rst_in),
    .high_in(hi), .low_in(lo), .load_dir_in(load_dir),
    .comp_sense_out(comp), .hi_n_out(hi_n), .lo_n_out(lo_n),
    .per_n_out(per_n), .seen_out(seen));
  // 20 MHz clock
  always #25 clk_sys_in = ~clk_sys_in;
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic hang();
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    conclude();
  endtask : hang
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) hang();
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rq, e);
  endtask : rd
  // Mode bits change only while the generator is stopped
  task automatic cfg(input logic [31:0] c);
    wr(8'h14, 32'h0);
    wr(8'h00, c);
    wr(8'h14, 32'h1);
  endtask : cfg
  // Wait for three fresh periods from the power stage
  task automatic meas();
    logic [7:0] s;
    int n = 0;
    s = seen;
    while (8'(seen - s) < 8'h03 && n < 3000) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 3000) hang();
  endtask : meas
  task automatic pulse();
    limit_pin <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    limit_pin <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
  endtask : pulse
  initial begin
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), i == 1 ? 32'hFF : 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, re}, 32'h1);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_02EF);
    // Edge counting: 64-cycle period, duty 32, dead time 4
    wr(8'h04, 32'h3F);
    wr(8'h08, 32'h20);
    wr(8'h10, 32'h4);
    for (int i = 0; i < 7; i++) begin
      load_dir <= tbl[i][16];
      cfg({22'h0, 2'h2, tbl[i][25:24], tbl[i][20], 5'h01});
      meas();
      chk(hi_n, tbl[i][15:8]);
      chk(lo_n, tbl[i][7:0]);
      chk(per_n, 32'h40);
    end
    // Center counting drops low bits of duty, dead time and period
    cfg(32'h205);
    wr(8'h10, 32'h7);
    wr(8'h08, 32'h27);
    meas();
    h1 = hi_n;
    chk(per_n, 32'h70);
    chk(hi_n, 32'h3F);
    chk(hi_n + lo_n, per_n);
    wr(8'h08, 32'h20);
    meas();
    chk(hi_n, h1);
    cfg(32'h5);
    meas();
    chk(per_n, 32'h40);
    // Secondary base has no ticks, so its count stays at the phase
    cfg(32'h209);
    repeat (8) @(posedge clk_sys_in);
    rd(8'h20, 32'h0);
    cfg(32'h201);
    apb(1'b0, 8'h20, 32'h0);
    q1 = rq;
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(rq != q1), 32'h1);
    // Limit event reloads phase only with the reset bit set
    cfg(32'h20B);
    wr(8'h0C, 32'h10);
    pulse();
    apb(1'b0, 8'h20, 32'h0);
    chk(rq[15:0], 32'h10);
    cfg(32'h209);
    wr(8'h0C, 32'h5);
    pulse();
    apb(1'b0, 8'h20, 32'h0);
    chk(rq[15:0], 32'h10);
    apb(1'b0, 8'h18, 32'h0);
    chk(rq[1], 32'h1);
    wr(8'h1C, 32'h2);
    repeat (3) @(posedge clk_sys_in);
    chk(irq, 32'h1);
    wr(8'h1C, 32'h0);
    repeat (3) @(posedge clk_sys_in);
    chk(irq, 32'h0);
    wr(8'h1C, 32'h2);
    wr(8'h18, 32'h3);
    repeat (3) @(posedge clk_sys_in);
    chk(irq, 32'h0);
    rd(8'h18, 32'h0);
    // Primary sync reloads phase while the independent base is off
    cfg(32'h1);
    repeat (4) @(posedge clk_sys_in);
    pri_tick <= 1'b0;
    pri_sync <= 1'b1;
    @(posedge clk_sys_in);
    pri_sync <= 1'b0;
    rd(8'h20, 32'h5);
    // Frozen count: duty change shows only when applied at once
    cfg(32'h289);
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h0);
    repeat (6) @(posedge clk_sys_in);
    chk({hi, lo}, 32'h1);
    cfg(32'h288);
    wr(8'h08, 32'hFFFF);
    repeat (6) @(posedge clk_sys_in);
    chk({hi, lo}, 32'h1);
    cfg(32'h289);
    wr(8'h08, 32'hFFFF);
    repeat (6) @(posedge clk_sys_in);
    chk({hi, lo}, 32'h2);
    conclude();
  end
endmodule : pgc_top_test
`default_nettype wire
